// ---- design/gpio_fmt_pkg.sv ----
// Constants and carrier types for the pin control and data format block
package gpio_fmt_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_PIN_LEVELS = 8'h95;
    localparam logic [7:0] OFS_IO_CONTROL = 8'h96;
    localparam logic [7:0] OFS_PIN4_CTRL = 8'h97;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int IOC_OUT1 = 7;
    localparam int IOC_OUT2 = 6;
    localparam int IOC_CFG_HI = 5;
    localparam int IOC_CFG_LO = 4;
    localparam int IOC_POL1 = 3;
    localparam int IOC_POL2 = 2;
    localparam int IOC_POL3 = 1;
    localparam int IOC_OUT3 = 0;
    localparam int P4C_ALERT = 7;
    localparam int P4C_OUT4 = 6;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] IOC_RESET = 8'h03;
    localparam logic [1:0] P4C_RESET = 2'h0;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int PULSE_LONG_US = 128;
    localparam int PULSE_SHORT_US = 16;
    localparam logic [11:0] PULSE_LONG_CYC = 12'(PULSE_LONG_US * CLK_MHZ);
    localparam logic [11:0] PULSE_SHORT_CYC =
        12'(PULSE_SHORT_US * CLK_MHZ);
    // Pin 3 configuration field
    typedef enum logic [1:0] {
        P3_GPIO = 2'b00,
        P3_PULSE16 = 2'b01,
        P3_PULSE128 = 2'b10,
        P3_LATCHED = 2'b11
    } pin3_mode_e;
    // Register access strobe group
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
    // Open-drain pin drive group
    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] o;
    } pin_drive_s;
endpackage : gpio_fmt_pkg

// ---- design/gpio_fmt.sv ----
// General purpose pin control, alert flag and result byte packing
`timescale 1ns/100ps
// Notes on behaviour
// - status bits 3..0 show pins 1..4
// - status upper nibble reads zero
// - io bits 7,6 pull pins 1,2
// - mode 11 holds pin3 low until read
// - mode 10 gives 128us low pulse
// - mode 01 gives 16us low pulse
// - mode 00 plain pin, reset value
// - io bit 3 pin1 alert polarity
// - io bit 2 pin2 alert polarity
// - io bit 1 pin3 polarity, resets one
// - io bit 0 pulls pin3 in mode 00 only, resets one
// - alert flag latches, cleared by host
// - pin4 control bit 6 pulls pin4
// - pin4 control low six read zero
// - two-byte 12/8-bit measurement layout
// - summed current uses same layout
// - power uses three-byte layout
// - summed power uses same layout
// - fault bits set at alert level
module gpio_fmt (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Register access from the serial host logic
    input wire gpio_fmt_pkg::reg_req_s req,
    output logic [7:0] rdata,
    // Open-drain pins 1..4 (index 0 is pin 1)
    input wire logic [3:0] pin_i,
    output gpio_fmt_pkg::pin_drive_s pin_drv,
    // Alert inputs and converter events
    input wire logic alert_event,
    input wire logic alert_clear_ctrl,
    input wire logic data_ready,
    input wire logic status_read,
    output logic [2:0] input_fault_bits,
    input wire logic [2:0] fault_clear,
    // Result formatting
    input wire logic mode_8bit,
    input wire logic [11:0] meas_val,
    input wire logic [23:0] power_val,
    output logic [15:0] meas_bytes,
    output logic [23:0] power_bytes
);
    import gpio_fmt_pkg::*;

    // State, next values and decoded strobes
    logic [1:0] sync_fill_q;
    logic [3:0] pin_meta_q, pin_sync_q;
    logic [7:0] ioc_q, ioc_d;
    logic [1:0] p4c_q, p4c_d;
    logic [2:0] fault_q, fault_d;
    logic [11:0] pulse_cnt_q, pulse_cnt_d;
    logic hold_q, hold_d;
    logic [15:0] meas_q, meas_d;
    logic [23:0] power_q, power_d;
    logic [7:0] rdata_q, rdata_d;
    logic [2:0] pol_lvl;
    logic ind_low;
    pin3_mode_e p3_mode;
    logic wr_ioc, wr_p4c;

    assign p3_mode = pin3_mode_e'(ioc_q[IOC_CFG_HI:IOC_CFG_LO]);
    assign wr_ioc = req.wr && req.addr == OFS_IO_CONTROL;
    assign wr_p4c = req.wr && req.addr == OFS_PIN4_CTRL;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Pins come from outside, two flops before anything reads them
    // The reset value of the pin flops is no real level, so fault
    // capture waits until the second flop holds a sampled pin
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
            sync_fill_q <= 2'h0;
        end else begin
            pin_meta_q <= pin_i;
            pin_sync_q <= pin_meta_q;
            sync_fill_q <= {sync_fill_q[0], 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // Control registers and flags
    // ----------------------------------------------------------------
    // Alert level per pin 1..3 given each polarity bit
    always_comb begin
        pol_lvl[0] = pin_sync_q[0] == ioc_q[IOC_POL1];
        pol_lvl[1] = pin_sync_q[1] == ioc_q[IOC_POL2];
        pol_lvl[2] = pin_sync_q[2] == ioc_q[IOC_POL3];
    end

    // Writes take effect at the next edge; host events are pulses
    always_comb begin
        ioc_d = ioc_q;
        p4c_d = p4c_q;
        fault_d = fault_q & ~fault_clear;
        // Nothing is captured until the synchroniser holds real levels
        if (sync_fill_q[1]) begin
            fault_d = fault_d | pol_lvl;
        end
        if (wr_ioc) begin
            ioc_d = req.wdata;
        end
        if (wr_p4c) begin
            p4c_d[0] = req.wdata[P4C_OUT4];
            // Only a zero clears; a written one is ignored
            if (!req.wdata[P4C_ALERT]) begin
                p4c_d[1] = 1'b0;
            end
        end
        if (alert_clear_ctrl) begin
            p4c_d[1] = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (alert_event) begin
            p4c_d[1] = 1'b1;
        end
    end

    // Pin 3 pulls low from reset, as its output bit resets to one
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ioc_q <= IOC_RESET;
            p4c_q <= P4C_RESET;
            fault_q <= 3'h0;
        end else begin
            ioc_q <= ioc_d;
            p4c_q <= p4c_d;
            fault_q <= fault_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin 3 data-ready indication
    // ----------------------------------------------------------------
    // A new ready restarts the pulse, so back-to-back events merge
    always_comb begin
        pulse_cnt_d = pulse_cnt_q;
        hold_d = hold_q;
        if (pulse_cnt_q != 12'h000) begin
            pulse_cnt_d = pulse_cnt_q - 12'h001;
        end
        if (data_ready && p3_mode == P3_PULSE128) begin
            pulse_cnt_d = PULSE_LONG_CYC;
        end
        if (data_ready && p3_mode == P3_PULSE16) begin
            pulse_cnt_d = PULSE_SHORT_CYC;
        end
        if (status_read || p3_mode != P3_LATCHED) begin
            hold_d = 1'b0;
        end
        if (data_ready && p3_mode == P3_LATCHED) begin
            hold_d = 1'b1;
        end
        // Plain pin and latched modes keep no pulse count running
        if (p3_mode == P3_GPIO || p3_mode == P3_LATCHED) begin
            pulse_cnt_d = 12'h000;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pulse_cnt_q <= 12'h000;
            hold_q <= 1'b0;
        end else begin
            pulse_cnt_q <= pulse_cnt_d;
            hold_q <= hold_d;
        end
    end

    assign ind_low = hold_q || pulse_cnt_q != 12'h000;

    // Open-drain drive: output value is always low, enable pulls
    always_comb begin
        pin_drv.o = 4'h0;
        pin_drv.oe[0] = ioc_q[IOC_OUT1];
        pin_drv.oe[1] = ioc_q[IOC_OUT2];
        if (p3_mode == P3_GPIO) begin
            pin_drv.oe[2] = ioc_q[IOC_OUT3];
        end else begin
            pin_drv.oe[2] = ind_low;
        end
        pin_drv.oe[3] = p4c_q[0];
    end

    // ----------------------------------------------------------------
    // Read data and result packing
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (req.rd) begin
            unique case (req.addr)
                OFS_PIN_LEVELS: rdata_d = {4'h0, pin_sync_q[0],
                    pin_sync_q[1], pin_sync_q[2],
                    pin_sync_q[3]};
                OFS_IO_CONTROL: rdata_d = ioc_q;
                OFS_PIN4_CTRL: rdata_d = {p4c_q[1], p4c_q[0], 6'h00};
                default: rdata_d = 8'h00;
            endcase
        end
        // Same packing for single and summed values
        if (mode_8bit) begin
            meas_d = {meas_val[7:0], 8'h00};
            power_d = {power_val[15:0], 8'h00};
        end else begin
            meas_d = {meas_val, 4'h0};
            power_d = power_val;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
            meas_q <= 16'h0000;
            power_q <= 24'h000000;
        end else begin
            rdata_q <= rdata_d;
            meas_q <= meas_d;
            power_q <= power_d;
        end
    end

    // Registered outputs
    assign rdata = rdata_q;
    assign meas_bytes = meas_q;
    assign power_bytes = power_q;
    assign input_fault_bits = fault_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_status_read: assert property (@(posedge core_clk) disable iff (!nrst)
        req.rd && req.addr == OFS_PIN_LEVELS |=>
        rdata[7:4] == 4'h0 && rdata[3] == $past(pin_sync_q[0]))
        else $error("pin level readback wrong");
    a_p4_low_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        req.rd && req.addr == OFS_PIN4_CTRL |=> rdata[5:0] == 6'h00)
        else $error("pin4 low bits not zero");
    a_alert_set: assert property (@(posedge core_clk) disable iff (!nrst)
        alert_event |=> p4c_q[1])
        else $error("alert flag not latched");
    a_alert_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        p4c_q[1] && !alert_clear_ctrl && !(wr_p4c && !req.wdata[7])
        |=> p4c_q[1])
        else $error("alert flag lost");
    a_latched_low: assert property (@(posedge core_clk) disable iff (!nrst)
        p3_mode == P3_LATCHED && data_ready && !wr_ioc ##1
        (!status_read && !wr_ioc) [*3] |-> pin_drv.oe[2])
        else $error("latched ready not held");
    a_pulse_short: assert property (@(posedge core_clk) disable iff (!nrst)
        p3_mode == P3_PULSE16 && data_ready && !wr_ioc |=>
        pulse_cnt_q == PULSE_SHORT_CYC && pin_drv.oe[2])
        else $error("short pulse not started");
    a_pulse_long: assert property (@(posedge core_clk) disable iff (!nrst)
        p3_mode == P3_PULSE128 && data_ready && !wr_ioc |=>
        pulse_cnt_q == PULSE_LONG_CYC)
        else $error("long pulse not started");
    a_gpio_out: assert property (@(posedge core_clk) disable iff (!nrst)
        p3_mode == P3_GPIO |-> pin_drv.oe[2] == ioc_q[0] &&
        pin_drv.oe[0] == ioc_q[7])
        else $error("plain pin drive wrong");
    a_meas_pack: assert property (@(posedge core_clk) disable iff (!nrst)
        !mode_8bit |=> meas_bytes[3:0] == 4'h0 &&
        meas_bytes[15:4] == $past(meas_val))
        else $error("12-bit packing wrong");
    a_fault_set: assert property (@(posedge core_clk) disable iff (!nrst)
        sync_fill_q[1] && pol_lvl[0] |=> input_fault_bits[0])
        else $error("fault bit not set");
    // Register side, pin 3 release, fault hold and result packing
    a_ready_release: assert property (@(posedge core_clk) disable iff (!nrst)
        status_read && !data_ready |=> !hold_q)
        else $error("latched ready not released");
    a_io_write: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_ioc |=> ioc_q == $past(req.wdata))
        else $error("io control write lost");
    a_alert_ignore: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_p4c && req.wdata[P4C_ALERT] && !p4c_q[1] && !alert_event
        |=> !p4c_q[1])
        else $error("written one set the alert flag");
    a_pin4_drive: assert property (@(posedge core_clk) disable iff (!nrst)
        wr_p4c |=> pin_drv.oe[3] == $past(req.wdata[P4C_OUT4]))
        else $error("pin4 drive not taken");
    a_meas_short: assert property (@(posedge core_clk) disable iff (!nrst)
        mode_8bit |=> meas_bytes[7:0] == 8'h00 &&
        meas_bytes[15:8] == $past(meas_val[7:0]))
        else $error("8-bit measurement packing wrong");
    a_power_pack: assert property (@(posedge core_clk) disable iff (!nrst)
        !mode_8bit |=> power_bytes == $past(power_val))
        else $error("12-bit power packing wrong");
    a_power_short: assert property (@(posedge core_clk) disable iff (!nrst)
        mode_8bit |=> power_bytes[7:0] == 8'h00 &&
        power_bytes[23:8] == $past(power_val[15:0]))
        else $error("8-bit power packing wrong");
    a_fault_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        input_fault_bits[2] && !fault_clear[2] |=> input_fault_bits[2])
        else $error("fault bit lost");
endmodule : gpio_fmt

// ---- tb/host_model.sv ----
// Register host model issuing one-cycle access strobes
`timescale 1ns/100ps
module host_model (
    // Clock
    input wire logic core_clk,
    // Register access
    output gpio_fmt_pkg::reg_req_s req,
    input wire logic [7:0] rdata
);
    import gpio_fmt_pkg::*;
    // Idle strobes so nothing is taken during reset
    initial req = '0;
    // --------
    // Access tasks
    // --------
    // Writing 0 to the alert bit is how the host clears it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk) req = '{1'b1, 1'b0, a, d};
        @(negedge core_clk) req = '0;
    endtask : wr
    // Sample late: read data is registered, so wait a full cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk) req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk) req = '0;
        @(negedge core_clk) d = rdata;
    endtask : rd
endmodule : host_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the pin control and format block
`timescale 1ns/100ps
module tb_top;
    import gpio_fmt_pkg::*;
    // --------
    // Signals
    // --------
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    reg_req_s req;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic [3:0] ext_lvl = 4'hF;
    logic [3:0] pin_i;
    pin_drive_s pin_drv;
    logic [4:0] ev = 5'h00;
    logic [2:0] input_fault_bits;
    logic mode_8bit = 1'b0;
    logic [11:0] meas_val = 12'hABC;
    logic [23:0] power_val = 24'h123456;
    logic [15:0] meas_bytes;
    logic [23:0] power_bytes;
    int mismatches = 0;
    int checks_done = 0;
    // 25 MHz clock
    always #20 core_clk = ~core_clk;
    // Pull-ups on every pin; an enabled open drain wins the wire
    assign pin_i = ext_lvl & ~pin_drv.oe;
    host_model i_host_model (.core_clk(core_clk), .req(req),
        .rdata(rdata));
    gpio_fmt i_gpio_fmt (.core_clk(core_clk), .nrst(nrst), .req(req),
        .rdata(rdata), .pin_i(pin_i), .pin_drv(pin_drv),
        .alert_event(ev[0]), .alert_clear_ctrl(ev[1]),
        .data_ready(ev[2]), .status_read(ev[3]),
        .input_fault_bits(input_fault_bits),
        .fault_clear({3{ev[4]}}), .mode_8bit(mode_8bit),
        .meas_val(meas_val), .power_val(power_val),
        .meas_bytes(meas_bytes), .power_bytes(power_bytes));
    // --------
    // Helpers
    // --------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_cyc
    task automatic pulse(input int k);
        @(negedge core_clk) ev[k] = 1'b1;
        @(negedge core_clk) ev[k] = 1'b0;
    endtask : pulse
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_host_model.rd(a, rv);
        chk(24'(rv), 24'(e));
    endtask : rchk
    // --------
    // Scenarios
    // --------
    task automatic t_reset();
        rchk(OFS_IO_CONTROL, 8'h03);
        rchk(OFS_PIN4_CTRL, 8'h00);
        chk(24'(pin_drv.oe), 24'h4);
        chk(24'(pin_drv.o), 24'h0);
    endtask : t_reset
    task automatic t_regs();
        i_host_model.wr(OFS_IO_CONTROL, 8'hC0);
        wait_cyc(4);
        chk(24'(pin_drv.oe), 24'h3);
        rchk(OFS_PIN_LEVELS, 8'h03);
        i_host_model.wr(OFS_PIN_LEVELS, 8'hFF);
        rchk(OFS_PIN_LEVELS, 8'h03);
        i_host_model.wr(OFS_PIN4_CTRL, 8'h7F);
        rchk(OFS_PIN4_CTRL, 8'h40);
        chk(24'(pin_drv.oe), 24'hB);
        rchk(OFS_PIN_LEVELS, 8'h02);
        rchk(8'h50, 8'h00);
        i_host_model.wr(OFS_PIN4_CTRL, 8'h00);
    endtask : t_regs
    task automatic t_alert();
        i_host_model.wr(OFS_PIN4_CTRL, 8'h80);
        rchk(OFS_PIN4_CTRL, 8'h00);
        pulse(0);
        rchk(OFS_PIN4_CTRL, 8'h80);
        i_host_model.wr(OFS_PIN4_CTRL, 8'h00);
        rchk(OFS_PIN4_CTRL, 8'h00);
        pulse(0);
        rchk(OFS_PIN4_CTRL, 8'h80);
        pulse(1);
        rchk(OFS_PIN4_CTRL, 8'h00);
        // Event and clear in one cycle: the set must win
        @(negedge core_clk) ev[1:0] = 2'h3;
        @(negedge core_clk) ev[1:0] = 2'h0;
        rchk(OFS_PIN4_CTRL, 8'h80);
        i_host_model.wr(OFS_PIN4_CTRL, 8'h00);
    endtask : t_alert
    task automatic t_faults();
        i_host_model.wr(OFS_IO_CONTROL, 8'h08);
        ext_lvl = 4'b1101;
        wait_cyc(6);
        // Clear stale faults so only live levels can set them again
        pulse(4);
        chk(24'(input_fault_bits), 24'h3);
        ext_lvl = 4'hF;
        i_host_model.wr(OFS_IO_CONTROL, 8'h02);
        wait_cyc(6);
        pulse(4);
        wait_cyc(2);
        chk(24'(input_fault_bits), 24'h4);
    endtask : t_faults
    // Pin 3 output bit set: the indication mode must override it
    task automatic t_pulse(input logic [1:0] m, input int len);
        int n = 0;
        i_host_model.wr(OFS_IO_CONTROL, {2'b00, m, 4'h1});
        wait_cyc(2);
        chk(24'(pin_drv.oe), 24'h0);
        pulse(2);
        while (pin_drv.oe[2] !== 1'b1 && n < 5) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        while (pin_drv.oe[2] === 1'b1 && n < 4000) begin
            @(negedge core_clk);
            n++;
        end
        chk(24'(n), 24'(len));
    endtask : t_pulse
    task automatic t_latched();
        i_host_model.wr(OFS_IO_CONTROL, 8'h30);
        pulse(2);
        wait_cyc(50);
        chk(24'(pin_drv.oe), 24'h4);
        pulse(3);
        wait_cyc(2);
        chk(24'(pin_drv.oe), 24'h0);
        i_host_model.wr(OFS_IO_CONTROL, 8'h01);
        wait_cyc(2);
        chk(24'(pin_drv.oe), 24'h4);
    endtask : t_latched
    task automatic t_format();
        for (int b = 0; b < 2; b++) begin
            mode_8bit = 1'(b);
            wait_cyc(2);
            chk(24'(meas_bytes), b ? 24'hBC00 : 24'hABC0);
            chk(power_bytes, b ? 24'h345600 : 24'h123456);
        end
    endtask : t_format
    // --------
    // Sequence, watchdog and verdict
    // --------
    initial begin
        wait_cyc(8);
        nrst = 1'b1;
        wait_cyc(1);
        t_reset();
        t_regs();
        t_alert();
        t_faults();
        t_pulse(2'b01, 400);
        t_pulse(2'b10, 3200);
        t_latched();
        t_format();
        complete_run();
    end
    // Tests need about 4000 cycles; allow five times that
    initial begin
        #(40 * 20000);
        mismatches++;
        complete_run();
    end
    task automatic complete_run();
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
endmodule : tb_top
